// ==== verilog/fpec_regs.svh ====
`ifndef FPEC_REGS_SVH
`define FPEC_REGS_SVH
// register byte addresses on apb
`define FPEC_OFS_CONTROL      12'h000
`define FPEC_OFS_ADDR_LOW     12'h004
`define FPEC_OFS_ADDR_HIGH    12'h008
`define FPEC_OFS_UNLOCK_KEY   12'h00C
`define FPEC_OFS_SRC_LOW      12'h010
`define FPEC_OFS_SRC_HIGH     12'h014
`define FPEC_OFS_INJ_CTRL     12'h018
`define FPEC_OFS_INJ_PTRS     12'h01C
`define FPEC_OFS_INJ_ADDR_LOW 12'h020
`define FPEC_OFS_INJ_ADDR_HI  12'h024
// control and injection control register fields
`define FPEC_BIT_GO           15
`define FPEC_BIT_PGM_EN       14
`define FPEC_BIT_SEQ_ERR      13
`define FPEC_OP_LSB           0
`define FPEC_OP_MSB           3
`define FPEC_BIT_INJ_EN       0
// unlock key values
`define FPEC_KEY_FIRST        8'h55
`define FPEC_KEY_SECOND       8'hAA
// injection pointer range
`define FPEC_ECC_BITS         56
`define FPEC_PTR_MAX          8'h37
// reset values
`define FPEC_RST_ZERO16       16'h0000
`define FPEC_RST_OP           4'h0
// operation timing in microseconds and derived cycles
`define FPEC_CLK_MHZ          25
`define FPEC_T_WORD_US        20
`define FPEC_T_ROW_US         1500
`define FPEC_T_PAGE_US        20000
`define FPEC_T_BULK_US        40000
`endif

// ==== verilog/fpec_pkg.sv ====
package fpec_pkg;
    typedef enum logic [3:0] {
        FPEC_OP_DWORD    = 4'b0001,
        FPEC_OP_ROW      = 4'b0010,
        FPEC_OP_PAGE     = 4'b0011,
        FPEC_OP_INACTIVE = 4'b0100,
        FPEC_OP_BOOT_DW  = 4'b1000,
        FPEC_OP_BULK     = 4'b1110
    } fpec_op_t;
    typedef enum logic [1:0] {
        FPEC_KEY_IDLE  = 2'b00,
        FPEC_KEY_HALF  = 2'b01,
        FPEC_KEY_OPEN  = 2'b10
    } fpec_key_t;
    typedef enum logic [1:0] {
        FPEC_ST_IDLE   = 2'b00,
        FPEC_ST_RUN    = 2'b01
    } fpec_state_t;
endpackage : fpec_pkg

// ==== verilog/fpec_ctrl.sv ====
`timescale 1ns/1ns
`include "fpec_regs.svh"
// Overview of operation
// R01 - code 1110 bulk erases user flash
// R02 - 0011 page erase, 0010 row program
// R03 - 1000 programs boot config double word
// R04 - 0100 erases inactive partition only
// R05 - 0001 programs aligned adjacent word pair
// R06 - other codes launch no flash operation
// R07 - op select cleared by power-on only
// R08 - power-save ignored while operation runs
// R09 - low address gives bits 15..0
// R10 - high address bits 23..16, upper zero
// R11 - key register write-only, low byte
// R12 - row data fetched from source address
// R13 - bit 0 enables fault injection
// R14 - pointer 0..55 inverts that ecc bit
// R15 - pointer 56..255 inverts nothing
// R16 - two independent pointers in one register
// R17 - software writes 55 then AA first
// R18 - go bit launches, hardware clears at end
// R19 - no operation without program enable
// R20 - inject only on matching flash address
// R21 - unimplemented bits ignored, read zero
module fpec_ctrl #(
    parameter int T_WORD_CYC = `FPEC_T_WORD_US * `FPEC_CLK_MHZ,
    parameter int T_ROW_CYC  = `FPEC_T_ROW_US * `FPEC_CLK_MHZ,
    parameter int T_PAGE_CYC = `FPEC_T_PAGE_US * `FPEC_CLK_MHZ,
    parameter int T_BULK_CYC = `FPEC_T_BULK_US * `FPEC_CLK_MHZ
) (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        por_b,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        power_save_instr,
    output logic             sleep_grant,
    output logic             flash_op_valid,
    output logic [3:0]       flash_op_code,
    output logic [23:0]      flash_op_addr,
    output logic [23:0]      row_src_addr,
    input  wire logic [23:0] ecc_access_addr,
    input  wire logic [55:0] ecc_word_in,
    output logic      [55:0] ecc_word_out
);
    ////////////////////////////////////////////////////////////////////////
    logic [3:0]          flash_op_select;
    logic                go;
    logic                program_enable_gate;
    logic                seq_err;
    logic [15:0]         flash_addr_low;
    logic [7:0]          flash_addr_high;
    logic [15:0]         src_low;
    logic [7:0]          src_high;
    logic                inject_enable;
    logic [7:0]          inject_ptr_a;
    logic [7:0]          inject_ptr_b;
    logic [23:0]         inject_addr_match;
    fpec_pkg::fpec_key_t key_st;
    fpec_pkg::fpec_state_t st;
    logic [31:0]         op_cnt;
    logic                wr_acc;
    logic [3:0]          wr_op;
    logic                wr_op_legal;
    logic                op_legal;
    logic                launch;
    logic [31:0]         op_len;
    logic [15:0]         rd_word;

    // zero-wait slave: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wr_acc  = psel && penable && pwrite && clk_en;
    // the go write also loads the code, so judge the code being written
    assign wr_op   = pwdata[`FPEC_OP_MSB:`FPEC_OP_LSB];

    always_comb begin
        unique case (flash_op_select)
            fpec_pkg::FPEC_OP_DWORD,
            fpec_pkg::FPEC_OP_ROW,
            fpec_pkg::FPEC_OP_PAGE,
            fpec_pkg::FPEC_OP_INACTIVE,
            fpec_pkg::FPEC_OP_BOOT_DW,
            fpec_pkg::FPEC_OP_BULK: op_legal = 1'b1;
            default:                op_legal = 1'b0; // R06
        endcase
    end

    // only read at the launch edge, so it follows the written code
    always_comb begin
        unique case (wr_op)
            fpec_pkg::FPEC_OP_ROW:      op_len = T_ROW_CYC; // R02
            fpec_pkg::FPEC_OP_PAGE:     op_len = T_PAGE_CYC; // R02
            fpec_pkg::FPEC_OP_INACTIVE: op_len = T_BULK_CYC; // R04
            fpec_pkg::FPEC_OP_BULK:     op_len = T_BULK_CYC; // R01
            default:                    op_len = T_WORD_CYC; // R03 R05
        endcase
    end

    always_comb begin
        unique case (wr_op)
            fpec_pkg::FPEC_OP_DWORD,
            fpec_pkg::FPEC_OP_ROW,
            fpec_pkg::FPEC_OP_PAGE,
            fpec_pkg::FPEC_OP_INACTIVE,
            fpec_pkg::FPEC_OP_BOOT_DW,
            fpec_pkg::FPEC_OP_BULK: wr_op_legal = 1'b1;
            default:                wr_op_legal = 1'b0; // R06
        endcase
    end

    // gate is the stored bit: enable must be set before the go write
    assign launch = wr_acc && paddr == `FPEC_OFS_CONTROL
                    && pwdata[`FPEC_BIT_GO] && !go
                    && program_enable_gate // R19
                    && key_st == fpec_pkg::FPEC_KEY_OPEN // R17
                    && wr_op_legal; // R06

    ////////////////////////////////////////////////////////////////////////
    // unlock sequence; any other write in between relocks
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            key_st <= fpec_pkg::FPEC_KEY_IDLE;
        end else if (clk_en && wr_acc) begin
            if (paddr == `FPEC_OFS_UNLOCK_KEY
                && pwdata[7:0] == `FPEC_KEY_FIRST) begin // R11
                key_st <= fpec_pkg::FPEC_KEY_HALF;
            end else if (paddr == `FPEC_OFS_UNLOCK_KEY
                && pwdata[7:0] == `FPEC_KEY_SECOND
                && key_st == fpec_pkg::FPEC_KEY_HALF) begin
                key_st <= fpec_pkg::FPEC_KEY_OPEN; // R17
            end else begin
                key_st <= fpec_pkg::FPEC_KEY_IDLE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // por-only fields: system reset leaves them alone
    always_ff @(posedge core_clk) begin
        if (!por_b) begin
            flash_op_select     <= `FPEC_RST_OP; // R07
            program_enable_gate <= 1'b0;
            seq_err             <= 1'b0;
        end else if (clk_en && wr_acc && paddr == `FPEC_OFS_CONTROL) begin
            flash_op_select     <= pwdata[`FPEC_OP_MSB:`FPEC_OP_LSB];
            program_enable_gate <= pwdata[`FPEC_BIT_PGM_EN];
            // set on a refused go attempt, else software may clear
            seq_err <= (pwdata[`FPEC_BIT_GO] && !go && !launch)
                       || (seq_err && pwdata[`FPEC_BIT_SEQ_ERR]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // self-timed sequencer
    always_ff @(posedge core_clk) begin
        if (!por_b) begin
            st     <= fpec_pkg::FPEC_ST_IDLE;
            go     <= 1'b0;
            op_cnt <= 32'h0000_0000;
        end else if (clk_en) begin
            unique case (st)
                fpec_pkg::FPEC_ST_IDLE: begin
                    if (launch) begin
                        st     <= fpec_pkg::FPEC_ST_RUN;
                        go     <= 1'b1; // R18
                        op_cnt <= op_len - 32'h0000_0001;
                    end
                end
                fpec_pkg::FPEC_ST_RUN: begin
                    if (op_cnt == 32'h0000_0000) begin
                        st <= fpec_pkg::FPEC_ST_IDLE;
                        go <= 1'b0; // R18
                    end else begin
                        op_cnt <= op_cnt - 32'h0000_0001;
                    end
                end
            endcase
        end
    end

    // array command: R01 R02 R03 R04 R05 carried by code and address
    assign flash_op_valid = go;
    assign flash_op_code  = flash_op_select;
    assign flash_op_addr  = {flash_addr_high, flash_addr_low}; // R09 R10
    assign row_src_addr   = {src_high, src_low}; // R12
    assign sleep_grant    = power_save_instr && !go; // R08

    ////////////////////////////////////////////////////////////////////////
    // address and source registers; system reset loads zero into both
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            src_low         <= `FPEC_RST_ZERO16;
            src_high        <= 8'h00;
            flash_addr_low  <= `FPEC_RST_ZERO16;
            flash_addr_high <= 8'h00;
        end else if (clk_en && wr_acc && !go) begin
            unique case (paddr)
                `FPEC_OFS_ADDR_LOW:  flash_addr_low  <= pwdata[15:0]; // R09
                `FPEC_OFS_ADDR_HIGH: flash_addr_high <= pwdata[7:0]; // R10
                `FPEC_OFS_SRC_LOW:   src_low         <= pwdata[15:0]; // R12
                `FPEC_OFS_SRC_HIGH:  src_high        <= pwdata[7:0]; // R12
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fault injection setup
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            inject_enable     <= 1'b0;
            inject_ptr_a      <= 8'h00;
            inject_ptr_b      <= 8'h00;
            inject_addr_match <= 24'h00_0000;
        end else if (clk_en && wr_acc) begin
            unique case (paddr)
                `FPEC_OFS_INJ_CTRL:
                    inject_enable <= pwdata[`FPEC_BIT_INJ_EN]; // R13
                `FPEC_OFS_INJ_PTRS: begin
                    inject_ptr_a <= pwdata[7:0]; // R16
                    inject_ptr_b <= pwdata[15:8]; // R16
                end
                `FPEC_OFS_INJ_ADDR_LOW:
                    inject_addr_match[15:0] <= pwdata[15:0];
                `FPEC_OFS_INJ_ADDR_HI:
                    inject_addr_match[23:16] <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // combinational on the read path so data is not delayed a cycle
    always_comb begin
        ecc_word_out = ecc_word_in;
        if (inject_enable && ecc_access_addr == inject_addr_match) begin // R20
            for (int i = 0; i < `FPEC_ECC_BITS; i++) begin
                if (inject_ptr_a == 8'(i) || inject_ptr_b == 8'(i)) begin
                    ecc_word_out[i] = ~ecc_word_in[i]; // R14 R15
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux; key register reads zero, unused bits zero
    always_comb begin
        unique case (paddr)
            `FPEC_OFS_CONTROL: rd_word = {go, program_enable_gate, seq_err,
                                          9'h000, flash_op_select};
            `FPEC_OFS_ADDR_LOW:     rd_word = flash_addr_low;
            `FPEC_OFS_ADDR_HIGH:    rd_word = {8'h00, flash_addr_high}; // R10
            `FPEC_OFS_SRC_LOW:      rd_word = src_low;
            `FPEC_OFS_SRC_HIGH:     rd_word = {8'h00, src_high};
            `FPEC_OFS_INJ_CTRL:     rd_word = {15'h0000, inject_enable};
            `FPEC_OFS_INJ_PTRS:     rd_word = {inject_ptr_b, inject_ptr_a};
            `FPEC_OFS_INJ_ADDR_LOW: rd_word = inject_addr_match[15:0];
            `FPEC_OFS_INJ_ADDR_HI:  rd_word = {8'h00,
                                               inject_addr_match[23:16]};
            default:                rd_word = 16'h0000; // R11 R21
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            prdata <= 32'h0000_0000;
        end else if (clk_en && psel && !penable && !pwrite) begin
            // captured in setup so data is a flop by the access cycle
            prdata <= {16'h0000, rd_word}; // R21
        end
    end

    ////////////////////////////////////////////////////////////////////////
    AST_NO_GO_WITHOUT_EN: assert property (@(posedge core_clk) // R19
        disable iff (!por_b) $rose(go) |-> $past(program_enable_gate))
        else $error("operation started without enable gate");
    AST_NO_RESERVED: assert property (@(posedge core_clk) // R06
        disable iff (!por_b) $rose(go) |-> op_legal)
        else $error("reserved code launched");
    AST_KEY_NEEDED: assert property (@(posedge core_clk) // R17
        disable iff (!por_b)
        $rose(go) |-> $past(key_st) == fpec_pkg::FPEC_KEY_OPEN)
        else $error("launch without unlock");
    AST_SLEEP_BLOCK: assert property (@(posedge core_clk) // R08
        disable iff (!rst_b) go |-> !sleep_grant)
        else $error("sleep granted during operation");
    AST_GO_CLEARS: assert property (@(posedge core_clk) // R18
        disable iff (!por_b || !clk_en)
        (st == fpec_pkg::FPEC_ST_RUN && op_cnt == 32'h0000_0000)
        |=> !go)
        else $error("go not cleared at end");
    AST_PTR_HIGH_NONE: assert property (@(posedge core_clk) // R15
        disable iff (!rst_b)
        (inject_ptr_a > `FPEC_PTR_MAX && inject_ptr_b > `FPEC_PTR_MAX)
        |-> ecc_word_out == ecc_word_in)
        else $error("out of range pointer flipped a bit");
    AST_PTR_FLIP: assert property (@(posedge core_clk) // R14
        disable iff (!rst_b)
        (inject_enable && ecc_access_addr == inject_addr_match
         && inject_ptr_a <= `FPEC_PTR_MAX && inject_ptr_a != inject_ptr_b)
        |-> ecc_word_out[inject_ptr_a[5:0]] != ecc_word_in[inject_ptr_a[5:0]])
        else $error("pointer a bit not inverted");
    AST_NO_MATCH: assert property (@(posedge core_clk) // R20
        disable iff (!rst_b)
        (ecc_access_addr != inject_addr_match || !inject_enable)
        |-> ecc_word_out == ecc_word_in)
        else $error("injection off-address");
    AST_OP_PORONLY: assert property (@(posedge core_clk) // R07
        disable iff (!por_b) (!rst_b && !wr_acc)
        |=> $stable(flash_op_select))
        else $error("op select lost on system reset");
    AST_HIGH_ZERO: assert property (@(posedge core_clk) // R10
        disable iff (!rst_b) (psel && !penable && !pwrite && clk_en
        && paddr == `FPEC_OFS_ADDR_HIGH) |=> prdata[31:8] == 24'h00_0000)
        else $error("high address upper byte nonzero");
    AST_PTR_B_FLIP: assert property (@(posedge core_clk) // R16
        disable iff (!rst_b)
        (inject_enable && ecc_access_addr == inject_addr_match
         && inject_ptr_b <= `FPEC_PTR_MAX && inject_ptr_a != inject_ptr_b)
        |-> ecc_word_out[inject_ptr_b[5:0]] != ecc_word_in[inject_ptr_b[5:0]])
        else $error("pointer b bit not inverted");
    AST_KEY_READ_ZERO: assert property (@(posedge core_clk) // R11
        disable iff (!rst_b) (psel && !penable && !pwrite && clk_en
        && paddr == `FPEC_OFS_UNLOCK_KEY) |=> prdata == 32'h0000_0000)
        else $error("key register read back nonzero");
    AST_ADDR_FROZEN: assert property (@(posedge core_clk) // R09
        disable iff (!rst_b || !por_b) (go && $past(go))
        |-> $stable(flash_op_addr) && $stable(row_src_addr))
        else $error("target address changed during operation");

    COV_ROW: cover property (@(posedge core_clk)
        $rose(go) && flash_op_select == fpec_pkg::FPEC_OP_ROW);
    COV_BULK: cover property (@(posedge core_clk)
        $rose(go) && flash_op_select == fpec_pkg::FPEC_OP_BULK);
    COV_SEQERR: cover property (@(posedge core_clk) $rose(seq_err));
    COV_INJ: cover property (@(posedge core_clk)
        ecc_word_out != ecc_word_in);
    COV_KEY_OPEN: cover property (@(posedge core_clk)
        key_st == fpec_pkg::FPEC_KEY_OPEN);
endmodule : fpec_ctrl

// ==== verif/fpec_flash_model.sv ====
`timescale 1ns/1ns
// flash array stand-in: counts launches, returns a fixed code word
module fpec_flash_model #(
    parameter logic [55:0] WORD = 56'hA5_5A00_FF0F_F00F
) (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        flash_op_valid,
    input  wire logic [3:0]  flash_op_code,
    input  wire logic [23:0] row_src_addr,
    input  wire logic [23:0] rd_addr,
    output logic      [23:0] ecc_access_addr,
    output logic      [55:0] ecc_word_in,
    output int               op_cnt,
    output logic      [3:0]  last_code,
    output logic      [23:0] last_src
);
    logic valid_d;
    assign ecc_access_addr = rd_addr;
    assign ecc_word_in     = WORD;
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            valid_d   <= 1'h0;
            op_cnt    <= 0;
            last_code <= 4'h0;
            last_src  <= 24'h00_0000;
        end else begin
            valid_d <= flash_op_valid;
            // count only the rising edge, a long erase is one operation
            if (flash_op_valid && !valid_d) begin
                op_cnt    <= op_cnt + 1;
                last_code <= flash_op_code;
                last_src  <= row_src_addr;
            end
        end
    end
endmodule : fpec_flash_model

// ==== verif/flash_program_erase_ctrl_tb.sv ====
`timescale 1ns/1ns
`include "fpec_regs.svh"
module flash_program_erase_ctrl_tb;
    localparam logic [55:0] WORD = 56'hA5_5A00_FF0F_F00F;
    logic        core_clk = 1'h0;
    logic        rst_b = 1'h0;
    logic        por_b = 1'h0;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        power_save_instr = 1'h0;
    logic        clk_en = 1'h1;
    logic [23:0] rd_addr = 24'h00_0000;
    logic [31:0] prdata;
    logic        pready, pslverr, sleep_grant, flash_op_valid;
    logic [3:0]  flash_op_code, last_code;
    logic [23:0] flash_op_addr, row_src_addr, ecc_access_addr, last_src;
    logic [55:0] ecc_word_in, ecc_word_out;
    int          op_cnt;
    int          error_cnt = 0;
    int          tests_run = 0;
    always #20 core_clk = ~core_clk;
    fpec_ctrl #(.T_WORD_CYC(5), .T_ROW_CYC(6), .T_PAGE_CYC(7),
        .T_BULK_CYC(8)) u_dut (.core_clk(core_clk), .rst_b(rst_b),
        .por_b(por_b), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .power_save_instr(power_save_instr), .sleep_grant(sleep_grant),
        .flash_op_valid(flash_op_valid), .flash_op_code(flash_op_code),
        .flash_op_addr(flash_op_addr), .row_src_addr(row_src_addr),
        .ecc_access_addr(ecc_access_addr), .ecc_word_in(ecc_word_in),
        .ecc_word_out(ecc_word_out));
    fpec_flash_model #(.WORD(WORD)) u_flash (.core_clk(core_clk),
        .rst_b(rst_b), .flash_op_valid(flash_op_valid),
        .flash_op_code(flash_op_code), .row_src_addr(row_src_addr),
        .rd_addr(rd_addr), .ecc_access_addr(ecc_access_addr),
        .ecc_word_in(ecc_word_in), .op_cnt(op_cnt), .last_code(last_code),
        .last_src(last_src));
    ////////////////////////////////////////////////////////////////////////
    task complete_run();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run
    task check32(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %0t: got %h exp %h", $time, got, exp);
        end
    endtask : check32
    task check56(input logic [55:0] got, input logic [55:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %0t: word %h exp %h", $time, got, exp);
        end
    endtask : check56
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] r);
        int n;
        @(posedge core_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        r = prdata;
        check32({31'h0, pslverr}, 32'h0000_0000);
        psel <= 1'h0;
        penable <= 1'h0;
        if (pready !== 1'h1) begin
            error_cnt++;
            complete_run();
        end
    endtask : apb
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'h1, a, d, r);
    endtask : wr
    task rd(input logic [11:0] a, input logic [31:0] m, output logic [31:0] r);
        apb(1'h0, a, 32'h0000_0000, r);
        r = r & m;
    endtask : rd
    // bounded wait for the operation strobe to reach a level
    task wait_op(input logic lvl);
        int n;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (flash_op_valid !== lvl && n < 40);
        check32({31'h0, flash_op_valid}, {31'h0, lvl});
    endtask : wait_op
    ////////////////////////////////////////////////////////////////////////
    task t_reset();
        logic [31:0] r;
        for (int i = 0; i < 13; i++) begin
            rd(12'(i * 4), 32'hFFFF_FFFF, r);
            check32(r, 32'h0000_0000);
        end
    endtask : t_reset
    task t_regs();
        logic [31:0] r;
        wr(`FPEC_OFS_ADDR_LOW, 32'hFFFF_FFFF);
        wr(`FPEC_OFS_ADDR_HIGH, 32'hFFFF_FFFF);
        wr(`FPEC_OFS_SRC_LOW, 32'hFFFF_BEEF);
        wr(`FPEC_OFS_SRC_HIGH, 32'hFFFF_FF12);
        wr(`FPEC_OFS_UNLOCK_KEY, 32'h0000_0055);
        wr(`FPEC_OFS_INJ_CTRL, 32'hFFFF_FFFE);
        @(negedge core_clk);
        check32({8'h0, flash_op_addr}, 32'h00FF_FFFF);
        check32({8'h0, row_src_addr}, 32'h0012_BEEF);
        rd(`FPEC_OFS_ADDR_LOW, 32'hFFFF_FFFF, r);
        check32(r, 32'h0000_FFFF);
        rd(`FPEC_OFS_ADDR_HIGH, 32'hFFFF_FFFF, r);
        check32(r, 32'h0000_00FF);
        rd(`FPEC_OFS_UNLOCK_KEY, 32'hFFFF_FFFF, r);
        check32(r, 32'h0000_0000);
        rd(`FPEC_OFS_INJ_CTRL, 32'hFFFF_FFFF, r);
        check32(r, 32'h0000_0000);
        wr(`FPEC_OFS_INJ_PTRS, 32'hFFFF_ABCD);
        rd(`FPEC_OFS_INJ_PTRS, 32'hFFFF_FFFF, r);
        check32(r, 32'h0000_ABCD);
        // frozen clock enable: the write must not land
        clk_en <= 1'h0;
        wr(`FPEC_OFS_ADDR_LOW, 32'h0000_1234);
        clk_en <= 1'h1;
        rd(`FPEC_OFS_ADDR_LOW, 32'hFFFF_FFFF, r);
        check32(r, 32'h0000_FFFF);
    endtask : t_regs
    task launch(input logic [3:0] op, input logic unlock, input logic en);
        // gate and code first: the go write is judged on the stored gate
        wr(`FPEC_OFS_CONTROL, {16'h0, 1'h0, en, 10'h0, op});
        if (unlock) begin
            wr(`FPEC_OFS_UNLOCK_KEY, {24'h0, `FPEC_KEY_FIRST});
            wr(`FPEC_OFS_UNLOCK_KEY, {24'h0, `FPEC_KEY_SECOND});
        end
        wr(`FPEC_OFS_CONTROL, {16'h0, 1'h1, en, 10'h0, op});
    endtask : launch
    task t_ops();
        logic [3:0] ops [6];
        logic [31:0] r;
        ops = '{fpec_pkg::FPEC_OP_BULK, fpec_pkg::FPEC_OP_PAGE,
                fpec_pkg::FPEC_OP_ROW, fpec_pkg::FPEC_OP_BOOT_DW,
                fpec_pkg::FPEC_OP_INACTIVE, fpec_pkg::FPEC_OP_DWORD};
        power_save_instr <= 1'h1;
        for (int k = 0; k < 6; k++) begin
            launch(ops[k], 1'h1, 1'h1);
            wait_op(1'h1);
            check32({28'h0, flash_op_code}, {28'h0, ops[k]});
            check32({31'h0, sleep_grant}, 32'h0000_0000);
            wait_op(1'h0);
            check32({31'h0, sleep_grant}, 32'h0000_0001);
            check32(32'(op_cnt), 32'(k + 1));
            check32({28'h0, last_code}, {28'h0, ops[k]});
            rd(`FPEC_OFS_CONTROL, 32'h0000_800F, r);
            check32(r, {28'h0, ops[k]});
        end
        check32({8'h0, last_src}, 32'h0012_BEEF);
        power_save_instr <= 1'h0;
    endtask : t_ops
    task t_refuse();
        logic [31:0] r;
        int base;
        base = op_cnt;
        // reserved codes, missing unlock, missing enable gate
        launch(4'h0, 1'h1, 1'h1);
        repeat (10) @(negedge core_clk);
        launch(4'hF, 1'h1, 1'h1);
        repeat (10) @(negedge core_clk);
        check32(32'(op_cnt), 32'(base));
        launch(4'h3, 1'h0, 1'h1);
        repeat (10) @(negedge core_clk);
        check32(32'(op_cnt), 32'(base));
        launch(4'h3, 1'h1, 1'h0);
        repeat (10) @(negedge core_clk);
        check32(32'(op_cnt), 32'(base));
        rd(`FPEC_OFS_CONTROL, 32'h0000_2000, r);
        check32(r, 32'h0000_2000);
        wr(`FPEC_OFS_CONTROL, 32'h0000_0003);
        rd(`FPEC_OFS_CONTROL, 32'h0000_200F, r);
        check32(r, 32'h0000_0003);
    endtask : t_refuse
    task t_por();
        logic [31:0] r;
        @(posedge core_clk);
        rst_b <= 1'h0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'h1;
        rd(`FPEC_OFS_CONTROL, 32'h0000_000F, r);
        check32(r, 32'h0000_0003);
        por_b <= 1'h0;
        repeat (2) @(posedge core_clk);
        por_b <= 1'h1;
        rd(`FPEC_OFS_CONTROL, 32'h0000_000F, r);
        check32(r, 32'h0000_0000);
    endtask : t_por
    task inj(input logic [7:0] a, input logic [7:0] b, input logic en,
             input logic [23:0] addr);
        logic [55:0] w;
        w = WORD;
        if (en && addr == 24'h56_1234) begin
            if (a < 56) w[a] = ~w[a];
            if (b < 56) w[b] = ~w[b];
        end
        wr(`FPEC_OFS_INJ_PTRS, {16'h0, b, a});
        wr(`FPEC_OFS_INJ_CTRL, {31'h0, en});
        rd_addr <= addr;
        @(negedge core_clk);
        check56(ecc_word_out, w);
    endtask : inj
    task t_inj();
        wr(`FPEC_OFS_INJ_ADDR_LOW, 32'h0000_1234);
        wr(`FPEC_OFS_INJ_ADDR_HI, 32'h0000_0056);
        inj(8'h00, 8'h37, 1'h1, 24'h56_1234);
        inj(8'h38, 8'hFF, 1'h1, 24'h56_1234);
        inj(8'h37, 8'h38, 1'h1, 24'h56_1234);
        inj(8'h03, 8'h07, 1'h0, 24'h56_1234);
        inj(8'h03, 8'h07, 1'h1, 24'h56_1235);
    endtask : t_inj
    initial begin
        repeat (4) @(posedge core_clk);
        rst_b <= 1'h1;
        por_b <= 1'h1;
        t_reset();
        t_regs();
        t_ops();
        t_refuse();
        t_por();
        t_inj();
        complete_run();
    end
endmodule : flash_program_erase_ctrl_tb
